// >>> design/adcsp_top.sv
// adcsp_top: serial control and readout port of an eight-channel converter
// assumes: a serial master drives sclk and sync_n; the analog side presents
// sample_data on clk; master_clock_in arrives on a pin from outside
//
// Operation
// - convert on start pin pulse or control bit
// - two-wire: sample rising, drive after 16th edge
// - two-wire: float while select high, drive low
// - line reverts to input after sixteen read clocks
// - two-wire, select held low: the 16th edge of each sequence's last word flips direction
// - two-wire: calibration sequences run whole, direction held throughout
// - reset gives three-wire; control write selects two-wire
// - three-wire: select low drives output, falling edges shift
// - three-wire: output floats after select rises
// - three-wire: input sampled on rising serial edges
// - fourteen registers reachable through serial frames
// - power-on calibration runs on master clock
// - three-wire frames shift result and command together
// - all-zero word writes no register
// - status busy bit low means conversion done
// - every transfer is one sixteen-bit word
// - select falling with clock low presents the msb
`timescale 1ns/1ps
`include "adcsp_consts.svh"

module adcsp_top
    import adcsp_pkg::*;
#(
    parameter int CAL_EDGES  = `ADCSP_CAL_EDGES,
    parameter int CONV_EDGES = `ADCSP_CONV_EDGES
) (
    // system clock and reset
    input  wire logic                       clk,
    input  wire logic                       sys_rst,
    // serial link
    input  wire logic                       sclk,
    input  wire logic                       sync_n,
    input  wire logic                       din,
    output logic                            dout,
    output logic                            dout_oe_n,
    input  wire logic                       data_io_in,
    output logic                            data_io_out,
    output logic                            data_io_oe_n,
    // conversion control pins
    input  wire logic                       convert_start_n,
    input  wire logic                       master_clock_in,
    // analog side
    input  wire logic [`ADCSP_RES_W-1:0]    sample_data,
    output logic                            sample_strobe,
    // status
    output logic                            busy,
    output logic                            two_wire_mode
);

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------

    // an address that names a writable storage register
    function automatic logic writable(input logic [3:0] addr);
        writable = (addr != `ADCSP_ADDR_RESULT) && (addr != `ADCSP_ADDR_STATUS)
                && (addr <= `ADCSP_ADDR_LAST);
    endfunction

    // the word that a read of a given address shifts out
    function automatic logic [`ADCSP_WORD_W-1:0] read_mux(
        input logic [3:0]   addr,
        input adcsp_core_t  st
    );
        logic [`ADCSP_WORD_W-1:0] w;
        w = '0;
        if (addr == `ADCSP_ADDR_RESULT) begin
            w = {2'h0, st.result};
        end else if (addr == `ADCSP_ADDR_STATUS) begin
            w = {addr, 9'h000, st.conv == ADCSP_CAL,
                 st.regs[`ADCSP_ADDR_CTRL][`ADCSP_CTRL_TWO], st.busy};
        end else if (addr <= `ADCSP_ADDR_LAST) begin
            w = {addr, st.regs[addr]};
        end
        read_mux = w;
    endfunction

    // ------------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------------
    adcsp_core_t                s;
    adcsp_core_t                next_s;
    logic [`ADCSP_WORD_W-1:0]   rx_word;
    logic                       rx_tgl;
    logic                       tx_tgl;
    logic [3:0]                 synced;
    logic                       rx_evt;
    logic                       tx_evt;
    logic                       cs_rise;
    logic                       mclk_rise;
    logic                       sw_start;
    logic                       zero_word;
    logic [3:0]                 wr_addr;
    logic [`ADCSP_DATA_W-1:0]   ctrl;
    logic [3:0]                 rd_sel;
    logic [3:0]                 rd_addr;
    logic [19:0]                cal_last;
    logic [19:0]                conv_last;

    assign cal_last  = 20'(CAL_EDGES - 1);
    assign conv_last = 20'(CONV_EDGES - 1);
    assign ctrl      = s.regs[`ADCSP_ADDR_CTRL];
    assign rd_sel    = ctrl[`ADCSP_CTRL_RSEL_HI:`ADCSP_CTRL_RSEL_LO];

    // ------------------------------------------------------------------------
    // serial side and crossings
    // ------------------------------------------------------------------------
    adcsp_link u_link (
        .sclk         (sclk),
        .sys_rst      (sys_rst),
        .sync_n       (sync_n),
        .din          (din),
        .dout         (dout),
        .dout_oe_n    (dout_oe_n),
        .data_io_in   (data_io_in),
        .data_io_out  (data_io_out),
        .data_io_oe_n (data_io_oe_n),
        .two_wire_req (ctrl[`ADCSP_CTRL_TWO]),
        .seq_last     (ctrl[`ADCSP_CTRL_SEQ_HI:`ADCSP_CTRL_SEQ_LO]),
        .tx_word      (s.tx_word),
        .rx_word      (rx_word),
        .rx_tgl       (rx_tgl),
        .tx_tgl       (tx_tgl)
    );

    // toggles, start pin and master clock all enter through two flops;
    // rx_word itself stays still for fifteen serial clocks after its toggle
    adcsp_sync #(.W(4), .RST_VAL(4'h2)) u_sync (
        .clk (clk),
        .rst (sys_rst),
        .d   ({rx_tgl, tx_tgl, convert_start_n, master_clock_in}),
        .q   (synced)
    );

    // ------------------------------------------------------------------------
    // event decode
    // ------------------------------------------------------------------------
    assign rx_evt    = synced[3] != s.rx_seen;
    assign tx_evt    = synced[2] != s.tx_seen;
    assign cs_rise   = synced[1] & ~s.cs_prev;     // pulse ends on the rising edge
    assign mclk_rise = synced[0] & ~s.mclk_prev;
    assign zero_word = rx_word == '0;
    assign wr_addr   = rx_word[`ADCSP_ADDR_HI:`ADCSP_ADDR_LO];
    assign sw_start  = rx_evt && !zero_word && wr_addr == `ADCSP_ADDR_CTRL
                     && rx_word[`ADCSP_CTRL_CONV];

    // ------------------------------------------------------------------------
    // registers, read pointer and conversion sequencer
    // ------------------------------------------------------------------------
    always_comb begin
        next_s           = s;
        next_s.rx_seen   = synced[3];
        next_s.tx_seen   = synced[2];
        next_s.cs_prev   = synced[1];
        next_s.mclk_prev = synced[0];
        rd_addr          = '0;

        // an all-zero word is a pure read and touches nothing
        if (rx_evt && !zero_word && writable(wr_addr)) begin
            next_s.regs[wr_addr] = rx_word[`ADCSP_DATA_W-1:0];
            if (wr_addr == `ADCSP_ADDR_CTRL) begin
                // start bit is a trigger, never stored
                next_s.regs[wr_addr][`ADCSP_CTRL_CONV] = 1'b0;
                next_s.rd_idx = 2'h0;
            end
        end

        // two-wire calibration reads walk through the selected block word by word; three-wire reads stay on its first word
        if (tx_evt) begin
            if (s.rd_idx == ctrl[`ADCSP_CTRL_SEQ_HI:`ADCSP_CTRL_SEQ_LO]) begin
                next_s.rd_idx = 2'h0;
            end else begin
                next_s.rd_idx = s.rd_idx + 2'h1;
            end
        end
        if (rd_sel == `ADCSP_ADDR_RESULT) begin
            rd_addr = rd_sel;
        end else begin
            rd_addr = rd_sel + {2'h0, s.rd_idx};
        end
        // limitation: the link reads tx_word with no handshake, so a result or
        // status change inside a frame may tear the word; poll busy first
        next_s.tx_word = read_mux(rd_addr, s);

        // conversion and power-on calibration, timed on master clock edges
        case (s.conv)
            ADCSP_CAL: begin
                if (mclk_rise) begin
                    if (s.edges == cal_last) begin
                        next_s.conv  = ADCSP_IDLE;
                        next_s.edges = '0;
                    end else begin
                        next_s.edges = s.edges + 20'h1;
                    end
                end
            end
            ADCSP_IDLE: begin
                if (cs_rise || sw_start) begin
                    next_s.conv  = ADCSP_CONV;
                    next_s.edges = '0;
                end
            end
            ADCSP_CONV: begin
                if (mclk_rise) begin
                    if (s.edges == conv_last) begin
                        next_s.conv   = ADCSP_IDLE;
                        next_s.result = sample_data;
                        next_s.edges  = '0;
                    end else begin
                        next_s.edges = s.edges + 20'h1;
                    end
                end
            end
            default: begin
                next_s.conv = ADCSP_IDLE;
            end
        endcase
        next_s.busy = next_s.conv != ADCSP_IDLE;
    end

    // calibration starts on its own when reset releases
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s                           <= '0;
            s.conv                      <= ADCSP_CAL;
            s.busy                      <= 1'b1;
            s.regs[`ADCSP_ADDR_CTRL]    <= `ADCSP_CTRL_RST;
            s.cs_prev                   <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    assign busy          = s.busy;
    assign two_wire_mode = ctrl[`ADCSP_CTRL_TWO];
    assign sample_strobe = s.conv == ADCSP_CONV && mclk_rise && s.edges == conv_last;

    // ------------------------------------------------------------------------
    // checks on the system clock
    // ------------------------------------------------------------------------
    zero_write_a: assert property (@(posedge clk) disable iff (sys_rst)
        (rx_evt && zero_word) |=> $stable(s.regs))
        else $error("all-zero word changed a register");

    pin_start_a: assert property (@(posedge clk) disable iff (sys_rst)
        (s.conv == ADCSP_IDLE && cs_rise) |=> (busy && s.conv == ADCSP_CONV))
        else $error("start pin did not begin a conversion");

    mode_entry_a: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(two_wire_mode) |-> $past(rx_evt && wr_addr == `ADCSP_ADDR_CTRL))
        else $error("two-wire mode entered without a control write");

    busy_done_a: assert property (@(posedge clk) disable iff (sys_rst)
        (s.conv == ADCSP_CONV && mclk_rise && s.edges == conv_last)
        |=> (!busy && s.result == $past(sample_data)))
        else $error("conversion end not reported or result not taken");

    soft_start_a: assert property (@(posedge clk) disable iff (sys_rst)
        (s.conv == ADCSP_IDLE && sw_start) |=> (busy && s.conv == ADCSP_CONV))
        else $error("control bit did not begin a conversion");

    start_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
        !ctrl[`ADCSP_CTRL_CONV])
        else $error("start bit was stored in the control register");

    cal_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        (s.conv == ADCSP_CAL && !(mclk_rise && s.edges == cal_last))
        |=> (busy && s.conv == ADCSP_CAL))
        else $error("calibration left early");

    cal_done_a: assert property (@(posedge clk) disable iff (sys_rst)
        (s.conv == ADCSP_CAL && mclk_rise && s.edges == cal_last)
        |=> (!busy && s.conv == ADCSP_IDLE))
        else $error("calibration end not reported");

    result_word_a: assert property (@(posedge clk) disable iff (sys_rst)
        (rd_addr == `ADCSP_ADDR_RESULT) |=> (s.tx_word == {2'h0, $past(s.result)}))
        else $error("result read word not loaded");

    status_busy_a: assert property (@(posedge clk) disable iff (sys_rst)
        (rd_addr == `ADCSP_ADDR_STATUS) |=> (s.tx_word[0] == $past(s.busy)))
        else $error("status word does not show busy");

    strobe_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
        sample_strobe |=> !sample_strobe)
        else $error("sample strobe longer than one cycle");

endmodule

// >>> design/adcsp_consts.svh
// adcsp_consts.svh: offsets, field positions, reset values and timing counts
// assumes: included by bare name from the package and the design modules
`ifndef ADCSP_CONSTS_SVH
`define ADCSP_CONSTS_SVH

// ----------------------------------------------------------------------------
// serial word layout
// ----------------------------------------------------------------------------
`define ADCSP_WORD_W      16
`define ADCSP_ADDR_HI     15
`define ADCSP_ADDR_LO     12
`define ADCSP_DATA_W      12
`define ADCSP_RES_W       14
`define ADCSP_NUM_REGS    14

// ----------------------------------------------------------------------------
// register addresses (address 0 selects the conversion result on reads)
// ----------------------------------------------------------------------------
`define ADCSP_ADDR_RESULT 4'h0
`define ADCSP_ADDR_CTRL   4'h1
`define ADCSP_ADDR_STATUS 4'h2
`define ADCSP_ADDR_LAST   4'he

// ----------------------------------------------------------------------------
// control register fields and reset value
// ----------------------------------------------------------------------------
`define ADCSP_CTRL_CONV   0
`define ADCSP_CTRL_TWO    1
`define ADCSP_CTRL_RSEL_LO 2
`define ADCSP_CTRL_RSEL_HI 5
`define ADCSP_CTRL_SEQ_LO 6
`define ADCSP_CTRL_SEQ_HI 7
`define ADCSP_CTRL_RST    12'h000

// ----------------------------------------------------------------------------
// timing: figures in their own units, counts in master clock edges
// ----------------------------------------------------------------------------
`define ADCSP_MCLK_KHZ    6000
`define ADCSP_CONV_NS     3500
`define ADCSP_CAL_MS      150
`define ADCSP_CONV_EDGES  ((`ADCSP_CONV_NS * `ADCSP_MCLK_KHZ) / 1000000)
`define ADCSP_CAL_EDGES   (`ADCSP_CAL_MS * `ADCSP_MCLK_KHZ)

`endif

// >>> design/adcsp_pkg.sv
// adcsp_pkg: state types shared by the serial port modules
// assumes: constants come from adcsp_consts.svh
`include "adcsp_consts.svh"

package adcsp_pkg;

    // conversion sequencer, gray along calibrate -> idle -> convert
    typedef enum logic [1:0] {
        ADCSP_CAL  = 2'b00,
        ADCSP_IDLE = 2'b01,
        ADCSP_CONV = 2'b11
    } adcsp_conv_t;

    // core state on the system clock
    typedef struct packed {
        adcsp_conv_t                                     conv;
        logic                                            busy;
        logic [19:0]                                     edges;
        logic [`ADCSP_NUM_REGS:1][`ADCSP_DATA_W-1:0]     regs;
        logic [`ADCSP_RES_W-1:0]                         result;
        logic [1:0]                                      rd_idx;
        logic [`ADCSP_WORD_W-1:0]                        tx_word;
        logic                                            rx_seen;
        logic                                            tx_seen;
        logic                                            cs_prev;
        logic                                            mclk_prev;
    } adcsp_core_t;

    // link state cleared by frame select
    typedef struct packed {
        logic [3:0]                 cnt;
        logic [`ADCSP_WORD_W-1:0]   rx_sh;
    } adcsp_frame_t;

    // link state that survives between frames
    typedef struct packed {
        logic                       dir;
        logic [1:0]                 wcnt;
        logic                       rx_tgl;
        logic                       tx_tgl;
        logic [`ADCSP_WORD_W-1:0]   rx_word;
    } adcsp_seq_t;

endpackage

// >>> design/adcsp_sync.sv
// adcsp_sync: two flip-flop level synchroniser, one per bit
// assumes: inputs are levels that hold for several destination clocks
`timescale 1ns/1ps

module adcsp_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset of the destination domain
    input  wire logic           clk,
    input  wire logic           rst,
    // levels in and out
    input  wire logic [W-1:0]   d,
    output logic [W-1:0]        q
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } adcsp_sync_t;

    adcsp_sync_t s;
    adcsp_sync_t next_s;

    // first stage feeds only the second stage
    always_comb begin
        next_s.meta   = d;
        next_s.stable = s.meta;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= {RST_VAL, RST_VAL};
        end else begin
            s <= next_s;
        end
    end

    assign q = s.stable;

endmodule

// >>> design/adcsp_link.sv
// adcsp_link: serial shifter running on the serial clock
// assumes: tx_word and seq_last are quasi-static while a word is shifted
`timescale 1ns/1ps
`include "adcsp_consts.svh"

module adcsp_link
    import adcsp_pkg::*;
(
    // serial clock domain
    input  wire logic                       sclk,
    input  wire logic                       sys_rst,
    input  wire logic                       sync_n,
    // three-wire data lines
    input  wire logic                       din,
    output logic                            dout,
    output logic                            dout_oe_n,
    // two-wire shared data line
    input  wire logic                       data_io_in,
    output logic                            data_io_out,
    output logic                            data_io_oe_n,
    // core side
    input  wire logic                       two_wire_req,
    input  wire logic [1:0]                 seq_last,
    input  wire logic [`ADCSP_WORD_W-1:0]   tx_word,
    output logic [`ADCSP_WORD_W-1:0]        rx_word,
    output logic                            rx_tgl,
    output logic                            tx_tgl
);

    adcsp_frame_t fr;
    adcsp_frame_t next_fr;
    adcsp_seq_t   sq;
    adcsp_seq_t   next_sq;
    logic         tw;
    logic         frame_rst;
    logic         fell;
    logic         out_q;
    logic         rx_bit;
    logic         bit_out;

    // ------------------------------------------------------------------------
    // mode crossing and frame reset
    // ------------------------------------------------------------------------
    adcsp_sync #(.W(1), .RST_VAL(1'b0)) u_tw_sync (
        .clk (sclk),
        .rst (sys_rst),
        .d   (two_wire_req),
        .q   (tw)
    );

    // frame select high clears the partial word at once, clock or not
    assign frame_rst = sys_rst | sync_n;

    // ------------------------------------------------------------------------
    // rising edge: sample input, count bits, turn the line round
    // ------------------------------------------------------------------------
    always_comb begin
        next_fr = fr;
        next_sq = sq;
        rx_bit  = tw ? data_io_in : din;
        next_fr.cnt = fr.cnt + 4'h1;
        if (!sq.dir) begin
            next_fr.rx_sh = {fr.rx_sh[`ADCSP_WORD_W-2:0], rx_bit};
        end
        if (fr.cnt == 4'hf) begin
            // word boundary: hand the word over, possibly flip direction
            if (tw && sq.dir) begin
                next_sq.tx_tgl = ~sq.tx_tgl;
            end else begin
                next_sq.rx_tgl  = ~sq.rx_tgl;
                next_sq.rx_word = {fr.rx_sh[`ADCSP_WORD_W-2:0], rx_bit};
            end
            if (tw && sq.wcnt == seq_last) begin
                next_sq.dir  = ~sq.dir;
                next_sq.wcnt = 2'h0;
            end else if (tw) begin
                next_sq.wcnt = sq.wcnt + 2'h1;
            end
        end
        if (!tw) begin
            next_sq.dir  = 1'b0;
            next_sq.wcnt = 2'h0;
        end
    end

    always_ff @(posedge sclk or posedge frame_rst) begin
        if (frame_rst) begin
            fr <= '0;
        end else begin
            fr <= next_fr;
        end
    end

    // direction persists across frames so a pulsed select can split phases
    always_ff @(posedge sclk or posedge sys_rst) begin
        if (sys_rst) begin
            sq <= '0;
        end else begin
            sq <= next_sq;
        end
    end

    // ------------------------------------------------------------------------
    // falling edge: present the next result bit
    // ------------------------------------------------------------------------
    always_ff @(negedge sclk or posedge frame_rst) begin
        if (frame_rst) begin
            fell  <= 1'b0;
            out_q <= 1'b0;
        end else begin
            fell  <= 1'b1;
            out_q <= tx_word[~fr.cnt];
        end
    end

    // msb shows as soon as select falls; covers select falling with clock low
    assign bit_out      = fell ? out_q : tx_word[`ADCSP_WORD_W-1];
    assign dout         = bit_out;
    assign dout_oe_n    = sync_n | tw;
    assign data_io_out  = bit_out;
    assign data_io_oe_n = ~(tw & sq.dir & ~sync_n);
    assign rx_word      = sq.rx_word;
    assign rx_tgl       = sq.rx_tgl;
    assign tx_tgl       = sq.tx_tgl;

    // ------------------------------------------------------------------------
    // checks on the serial clock
    // ------------------------------------------------------------------------
    line_float_a: assert property (@(posedge sclk) disable iff (sys_rst)
        sync_n |-> (dout_oe_n && data_io_oe_n))
        else $error("data line driven while frame select high");

    three_drive_a: assert property (@(posedge sclk) disable iff (sys_rst)
        (!sync_n && !tw) |-> (!dout_oe_n && data_io_oe_n))
        else $error("three-wire output not enabled in frame");

    turn_round_a: assert property (@(posedge sclk) disable iff (sys_rst)
        (tw && $past(tw) && !sync_n && !sq.dir && fr.cnt == 4'hf && seq_last == 2'h0)
        |=> sq.dir)
        else $error("shared line did not turn to output after 16th edge");

    word_done_a: assert property (@(posedge sclk) disable iff (sys_rst)
        (!tw && !sync_n && fr.cnt == 4'hf) |=> (rx_tgl != $past(rx_tgl)))
        else $error("received word not handed over on 16th edge");

endmodule

// >>> tb/adcsp_master.sv
// adcsp_master: behavioural serial master for the converter port
// assumes: miso is the resolved read line; frames are started by the bench
`timescale 1ns/1ps

module adcsp_master (
    // link pins driven by the master
    output logic      sclk,
    output logic      sync_n,
    output logic      mosi,
    // read data seen by the master
    input  wire logic miso
);
    // --------------------------------------------------------------
    // idle: select high, gated clock parked high
    // --------------------------------------------------------------
    initial begin
        sclk = 1'b1;
        sync_n = 1'b1;
        mosi = 1'b0;
    end

    // one word msb first; drv low releases the line to a toggling pattern
    task automatic xfer(input logic [15:0] w, input logic drv, output logic [15:0] r);
        #13;
        sync_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            mosi = drv ? w[i] : ~mosi;
            sclk = 1'b0;
            #62.5;
            sclk = 1'b1;
            r[i] = miso;
            #62.5;
        end
    endtask

    // raising select also clears any partial word
    task automatic done();
        sync_n = 1'b1;
        #250;
    endtask
endmodule

// >>> tb/adcsp_top_tb_top.sv
// adcsp_top_tb_top: self-checking bench for the serial port
// assumes: calibration shortened to 8 master clock edges
`timescale 1ns/1ps

module adcsp_top_tb_top;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        convert_start_n = 1'b1;
    logic        master_clock_in = 1'b0;
    logic [13:0] sample_data = 14'h0000;
    logic [15:0] r;
    wire         sclk, sync_n, mosi, dout, dout_oe_n, data_io_out, data_io_oe_n;
    wire         busy, two_wire_mode, sample_strobe;
    int          error_cnt = 0;
    int          compares = 0;
    int          strobes = 0;
    // shared line resolved from both drivers
    wire         line_io = data_io_oe_n ? mosi : data_io_out;

    // ------------------------------------------------------------
    // clocks and instances
    // ------------------------------------------------------------
    always #20 clk = ~clk;
    always #100 master_clock_in = ~master_clock_in;

    // conversion ends seen on the analog side
    always @(posedge clk) begin
        if (sample_strobe) strobes <= strobes + 1;
    end

    adcsp_master m (.sclk(sclk), .sync_n(sync_n), .mosi(mosi),
        .miso(dout_oe_n ? line_io : dout));
    adcsp_top #(.CAL_EDGES(8)) dut (.clk(clk), .sys_rst(sys_rst), .sclk(sclk),
        .sync_n(sync_n), .din(mosi), .dout(dout), .dout_oe_n(dout_oe_n),
        .data_io_in(line_io), .data_io_out(data_io_out), .data_io_oe_n(data_io_oe_n),
        .convert_start_n(convert_start_n), .master_clock_in(master_clock_in),
        .sample_data(sample_data), .sample_strobe(sample_strobe), .busy(busy),
        .two_wire_mode(two_wire_mode));

    task automatic chk(input string what, input logic [15:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    // bounded wait for busy to reach a level
    task automatic wbusy(input logic v);
        for (int n = 0; n < 400 && busy !== v; n++) @(posedge clk);
        chk("busy", {15'h0, busy}, {15'h0, v});
    endtask

    task automatic wr(input logic [15:0] w);
        m.xfer(w, 1'b1, r);
        m.done();
    endtask

    task automatic tally_and_finish();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        chk("busy in reset", {15'h0, busy}, 16'h1);
        chk("mode in reset", {15'h0, two_wire_mode}, 16'h0);
        sys_rst <= 1'b0;
        wbusy(1'b0);
        sample_data <= 14'h2a5c;
        convert_start_n <= 1'b0;
        repeat (3) @(posedge clk);
        convert_start_n <= 1'b1;
        wbusy(1'b1);
        wbusy(1'b0);
        wr(16'h100c);
        wr(16'h3abc);
        m.xfer(16'h0000, 1'b1, r);
        chk("dout oe", {15'h0, dout_oe_n}, 16'h0);
        chk("readback", r, 16'h3abc);
        m.done();
        chk("dout float", {15'h0, dout_oe_n}, 16'h1);
        // start by control bit with the status word selected for reading
        wr(16'h1009);
        m.xfer(16'h0000, 1'b1, r);
        chk("status busy", r, 16'h2001);
        m.done();
        wbusy(1'b1);
        wbusy(1'b0);
        m.xfer(16'h0000, 1'b1, r);
        chk("status done", r, 16'h2000);
        m.done();
        wr(16'h1002);
        repeat (8) @(posedge clk);
        chk("mode", {15'h0, two_wire_mode}, 16'h1);
        sample_data <= 14'h1357;
        convert_start_n <= 1'b0;
        repeat (3) @(posedge clk);
        convert_start_n <= 1'b1;
        wbusy(1'b1);
        wbusy(1'b0);
        m.xfer(16'h1002, 1'b1, r);
        chk("turnaround", {15'h0, data_io_oe_n}, 16'h0);
        m.xfer(16'h0000, 1'b0, r);
        chk("result", r, {2'b00, 14'h1357});
        chk("release", {15'h0, data_io_oe_n}, 16'h1);
        m.done();
        chk("strobes", strobes[15:0], 16'h3);
        tally_and_finish();
    end

    // watchdog well past the expected 33 us of traffic
    initial begin
        #100us;
        error_cnt++;
        tally_and_finish();
    end
endmodule
